// ### mls_defs.vh
/*
 * sequencer constants: op codes, access sizes, states, buffer size.
 * assumes inclusion by bare name.
 */
`ifndef MLS_DEFS_VH
`define MLS_DEFS_VH

// ***********************************************
// operation codes on cmd_op
// ***********************************************
`define MLS_OP_LHBR   4'h0
`define MLS_OP_LWBR   4'h1
`define MLS_OP_STHBR  4'h2
`define MLS_OP_STWBR  4'h3
`define MLS_OP_LMW    4'h4
`define MLS_OP_STMW   4'h5
`define MLS_OP_LSI    4'h6
`define MLS_OP_LSX    4'h7
`define MLS_OP_STSI   4'h8
`define MLS_OP_STSX   4'h9

// ***********************************************
// memory access sizes on mem_size
// ***********************************************
`define MLS_SZ_BYTE   2'h0
`define MLS_SZ_HALF   2'h1
`define MLS_SZ_WORD   2'h2

// ***********************************************
// sequencer states
// ***********************************************
`define MLS_ST_IDLE   2'h0
`define MLS_ST_FETCH  2'h1
`define MLS_ST_ISSUE  2'h2
`define MLS_ST_DRAIN  2'h3

// ***********************************************
// counts and buffer geometry
// ***********************************************
`define MLS_REG_COUNT 6'h20
`define MLS_STR_MAX   7'h20
`define MLS_XER_CNT_W 7
`define MLS_FIFO_W    32
`define MLS_FIFO_D    16
`define MLS_FIFO_AW   4

`endif

// ### mls_sequencer.v
/*
 * load/store sequencer: byte-reversed, multiple and string transfers,
 * with the load return buffer.
 * assumes a same-clock register file with combinational reads, and a
 * memory port returning one read beat per request, in order.
 */
`include "mls_defs.vh"
`default_nettype none

// ***********************************************
// load return buffer
// ***********************************************
module mls_fifo
#(
    parameter W  = `MLS_FIFO_W,
    parameter D  = `MLS_FIFO_D,
    parameter AW = `MLS_FIFO_AW
)
(
    input  wire          clk,       // core clock
    input  wire          reset_n,   // async reset, active low
    input  wire          in_valid,  // write side offers a word
    output wire          in_ready,  // buffer has room
    input  wire [W-1:0]  in_data,   // word written
    output wire          out_valid, // buffer holds a word
    input  wire          out_ready, // read side takes the word
    output wire [W-1:0]  out_data   // oldest word
);
    reg [W-1:0]  mem_reg [0:D-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0]   count_reg;
    wire         push;
    wire         pop;

    assign in_ready  = (count_reg != D[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule // mls_fifo

// ***********************************************
// sequencer
// ***********************************************
module mls_sequencer
(
    input  wire        clk,                        // core clock, 20 MHz
    input  wire        reset_n,                    // async reset, active low
    input  wire        cmd_valid,                  // decode offers an operation
    output wire        cmd_ready,                  // sequencer idle, takes it
    input  wire [3:0]  cmd_op,                     // operation code
    input  wire [4:0]  target_reg_field,           // first data register
    input  wire [4:0]  base_reg_field,             // base register, 0 = zero
    input  wire [4:0]  index_reg_field,            // index register
    input  wire [4:0]  immediate_byte_count_field, // string count, 0 = 32
    input  wire [15:0] cmd_disp,                   // multiple-word displacement
    input  wire [31:0] fixed_point_exception_reg,  // count in low 7 bits
    output wire [4:0]  rf_raddr_a,                 // read port a address
    input  wire [31:0] rf_rdata_a,                 // read port a data
    output wire [4:0]  rf_raddr_b,                 // read port b address
    input  wire [31:0] rf_rdata_b,                 // read port b data
    output wire        rf_we,                      // register write valid
    input  wire        rf_wready,                  // register write taken
    output wire [4:0]  rf_waddr,                   // register write address
    output wire [31:0] rf_wdata,                   // register write data
    output wire        mem_valid,                  // memory request valid
    input  wire        mem_ready,                  // memory request taken
    output wire        mem_we,                     // request is a store
    output wire [1:0]  mem_size,                   // byte, half or word
    output wire [31:0] mem_addr,                   // byte address
    output wire [31:0] mem_wdata,                  // store data, low aligned
    input  wire        mem_rvalid,                 // read data valid
    output wire        mem_rready,                 // read data taken
    input  wire [31:0] mem_rdata,                  // read data, low aligned
    output wire        busy,                       // operation in progress
    output wire        done                        // operation finished pulse
);
    reg  [1:0]  state_reg;
    reg  [3:0]  op_reg;
    reg  [31:0] addr_reg;
    reg  [6:0]  cnt_reg;
    reg  [4:0]  sreg_reg;
    reg  [1:0]  sbidx_reg;
    reg  [31:0] wdata_reg;
    reg  [6:0]  rcv_left_reg;
    reg  [4:0]  wreg_reg;
    reg  [1:0]  wbidx_reg;
    reg  [31:0] acc_reg;
    reg         wr_valid_reg;
    reg  [4:0]  wr_addr_reg;
    reg  [31:0] wr_data_reg;
    reg         done_reg;

    reg  [31:0] ea;
    reg  [6:0]  count;
    reg         is_store;
    wire        is_str_op;
    wire        is_word_op;
    wire        accept;
    wire        issue_fire;
    wire [31:0] base_val;
    wire [4:0]  rd_shift;
    wire [7:0]  st_byte;
    wire        q_valid;
    wire        q_ready;
    wire [31:0] q_data;
    wire [4:0]  wr_shift;
    wire [31:0] acc_new;
    wire        str_flush;

    assign cmd_ready  = (state_reg == `MLS_ST_IDLE);
    assign accept     = cmd_valid && cmd_ready;
    assign busy       = !cmd_ready;
    assign done       = done_reg;
    assign issue_fire = (state_reg == `MLS_ST_ISSUE) && mem_ready;
    assign is_str_op  = (op_reg >= `MLS_OP_LSI);
    assign is_word_op = (op_reg == `MLS_OP_LWBR) || (op_reg == `MLS_OP_STWBR) ||
                        (op_reg == `MLS_OP_LMW) || (op_reg == `MLS_OP_STMW);

    assign rf_raddr_a = (state_reg == `MLS_ST_IDLE) ? base_reg_field : sreg_reg;
    assign rf_raddr_b = index_reg_field;
    assign base_val   = (base_reg_field == 5'h00) ? 32'h0 : rf_rdata_a;

    // ***********************************************
    // address and count at acceptance
    // ***********************************************
    always @*
    begin
        ea       = base_val;
        count    = 7'h01;
        is_store = 1'b0;
        case (cmd_op)
            `MLS_OP_LHBR, `MLS_OP_LWBR:
                ea = base_val + rf_rdata_b;
            `MLS_OP_STHBR, `MLS_OP_STWBR:
            begin
                ea       = base_val + rf_rdata_b;
                is_store = 1'b1;
            end
            `MLS_OP_LMW, `MLS_OP_STMW:
            begin
                ea       = base_val + {{16{cmd_disp[15]}}, cmd_disp};
                count    = {1'b0, `MLS_REG_COUNT - {1'b0, target_reg_field}};
                is_store = (cmd_op == `MLS_OP_STMW);
            end
            `MLS_OP_LSI, `MLS_OP_STSI:
            begin
                count    = (immediate_byte_count_field == 5'h00) ? `MLS_STR_MAX :
                           {2'b00, immediate_byte_count_field};
                is_store = (cmd_op == `MLS_OP_STSI);
            end
            `MLS_OP_LSX, `MLS_OP_STSX:
            begin
                ea       = base_val + rf_rdata_b;
                count    = fixed_point_exception_reg[`MLS_XER_CNT_W-1:0];
                is_store = (cmd_op == `MLS_OP_STSX);
            end
            default:
                count = 7'h00;
        endcase
    end

    // ***********************************************
    // request side
    // ***********************************************
    // store byte picked from msb downward
    assign rd_shift = {~sbidx_reg, 3'b000};
    assign st_byte  = rf_rdata_a[rd_shift +: 8];

    assign mem_valid = (state_reg == `MLS_ST_ISSUE);
    assign mem_we    = (op_reg == `MLS_OP_STHBR) || (op_reg == `MLS_OP_STWBR) ||
                       (op_reg == `MLS_OP_STMW) || (op_reg == `MLS_OP_STSI) ||
                       (op_reg == `MLS_OP_STSX);
    assign mem_size  = is_str_op ? `MLS_SZ_BYTE :
                       (is_word_op ? `MLS_SZ_WORD : `MLS_SZ_HALF);
    assign mem_addr  = addr_reg;
    assign mem_wdata = wdata_reg;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= `MLS_ST_IDLE;
            op_reg    <= 4'h0;
            addr_reg  <= 32'h0;
            cnt_reg   <= 7'h00;
            sreg_reg  <= 5'h00;
            sbidx_reg <= 2'h0;
            wdata_reg <= 32'h0;
            done_reg  <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                `MLS_ST_IDLE:
                    if (accept)
                    begin
                        op_reg    <= cmd_op;
                        addr_reg  <= ea;
                        cnt_reg   <= count;
                        sreg_reg  <= target_reg_field;
                        sbidx_reg <= 2'h0;
                        if (count == 7'h00)
                            done_reg <= 1'b1;
                        else if (is_store)
                            state_reg <= `MLS_ST_FETCH;
                        else
                            state_reg <= `MLS_ST_ISSUE;
                    end
                `MLS_ST_FETCH:
                begin
                    case (op_reg)
                        `MLS_OP_STHBR:
                            wdata_reg <= {16'h0, rf_rdata_a[7:0], rf_rdata_a[15:8]};
                        `MLS_OP_STWBR:
                            wdata_reg <= {rf_rdata_a[7:0], rf_rdata_a[15:8],
                                          rf_rdata_a[23:16], rf_rdata_a[31:24]};
                        `MLS_OP_STMW:
                            wdata_reg <= rf_rdata_a;
                        default:
                            wdata_reg <= {24'h0, st_byte};
                    endcase
                    state_reg <= `MLS_ST_ISSUE;
                end
                `MLS_ST_ISSUE:
                    if (mem_ready)
                    begin
                        cnt_reg <= cnt_reg - 7'h01;
                        addr_reg <= addr_reg + (is_str_op ? 32'h1 :
                                                (is_word_op ? 32'h4 : 32'h2));
                        if (is_str_op)
                        begin
                            sbidx_reg <= sbidx_reg + 2'h1;
                            // next register, 31 wraps to 0
                            if (sbidx_reg == 2'h3)
                                sreg_reg <= sreg_reg + 5'h01;
                        end
                        else
                            sreg_reg <= sreg_reg + 5'h01;
                        if (cnt_reg == 7'h01)
                        begin
                            state_reg <= mem_we ? `MLS_ST_IDLE : `MLS_ST_DRAIN;
                            done_reg  <= mem_we;
                        end
                        else if (mem_we)
                            state_reg <= `MLS_ST_FETCH;
                    end
                `MLS_ST_DRAIN:
                    if (rcv_left_reg == 7'h00 && !wr_valid_reg)
                    begin
                        state_reg <= `MLS_ST_IDLE;
                        done_reg  <= 1'b1;
                    end
                default:
                    state_reg <= `MLS_ST_IDLE;
            endcase
        end
    end

    // ***********************************************
    // return side
    // ***********************************************
    // the buffer stalls memory when register writes back up
    mls_fifo
    #(
        .W  (`MLS_FIFO_W),
        .D  (`MLS_FIFO_D),
        .AW (`MLS_FIFO_AW)
    )
    u_fifo
    (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (mem_rvalid),
        .in_ready  (mem_rready),
        .in_data   (mem_rdata),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    assign q_ready   = !wr_valid_reg || rf_wready;
    assign wr_shift  = {~wbidx_reg, 3'b000};
    // bytes land from the msb down
    assign acc_new   = acc_reg | ({24'h0, q_data[7:0]} << wr_shift);
    assign str_flush = (wbidx_reg == 2'h3) || (rcv_left_reg == 7'h01);

    assign rf_we    = wr_valid_reg;
    assign rf_waddr = wr_addr_reg;
    assign rf_wdata = wr_data_reg;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rcv_left_reg <= 7'h00;
            wreg_reg     <= 5'h00;
            wbidx_reg    <= 2'h0;
            acc_reg      <= 32'h0;
            wr_valid_reg <= 1'b0;
            wr_addr_reg  <= 5'h00;
            wr_data_reg  <= 32'h0;
        end
        else
        begin
            if (wr_valid_reg && rf_wready)
                wr_valid_reg <= 1'b0;
            if (accept)
            begin
                rcv_left_reg <= is_store ? 7'h00 : count;
                wreg_reg     <= target_reg_field;
                wbidx_reg    <= 2'h0;
                acc_reg      <= 32'h0;
            end
            else if (q_valid && q_ready)
            begin
                rcv_left_reg <= rcv_left_reg - 7'h01;
                wr_addr_reg  <= wreg_reg;
                if (is_str_op)
                begin
                    wbidx_reg <= wbidx_reg + 2'h1;
                    if (str_flush)
                    begin
                        wr_valid_reg <= 1'b1;
                        wr_data_reg  <= acc_new;
                        acc_reg      <= 32'h0;
                        wreg_reg     <= wreg_reg + 5'h01;
                    end
                    else
                        acc_reg <= acc_new;
                end
                else
                begin
                    wr_valid_reg <= 1'b1;
                    wreg_reg     <= wreg_reg + 5'h01;
                    case (op_reg)
                        `MLS_OP_LHBR:
                            wr_data_reg <= {16'h0, q_data[7:0], q_data[15:8]};
                        `MLS_OP_LWBR:
                            wr_data_reg <= {q_data[7:0], q_data[15:8],
                                            q_data[23:16], q_data[31:24]};
                        default:
                            wr_data_reg <= q_data;
                    endcase
                end
            end
        end
    end
endmodule // mls_sequencer

`default_nettype wire

// ### mls_seq_chk.sv
/*
 * sequencer checker: handshakes, addresses, counts.
 * assumes binding to mls_sequencer, ports only.
 */
`include "mls_defs.vh"
`default_nettype none

// ****************************************
// transfer checks
// ****************************************
module mls_seq_chk (
    input wire logic        clk, reset_n, cmd_valid, cmd_ready, busy, done,
    input wire logic        rf_we, rf_wready, mem_valid, mem_ready, mem_we,
    input wire logic        mem_rvalid, mem_rready,
    input wire logic [3:0]  cmd_op,
    input wire logic [4:0]  target_reg_field, base_reg_field, rf_waddr,
    input wire logic [4:0]  immediate_byte_count_field,
    input wire logic [15:0] cmd_disp,
    input wire logic [1:0]  mem_size,
    input wire logic [31:0] fixed_point_exception_reg, rf_rdata_a, rf_rdata_b,
    input wire logic [31:0] mem_addr, mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        acc, mhs, whs, c_st, st_reg, first_reg;
    logic [1:0]  c_sz, sz_reg;
    logic [4:0]  wa_reg;
    logic [7:0]  c_req, c_wr, req_reg, wr_reg, rcnt_reg, wcnt_reg;
    logic [31:0] base, c_ea, ea_reg, last_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    assign acc = cmd_valid && cmd_ready;
    assign mhs = mem_valid && mem_ready;
    assign whs = rf_we && rf_wready;

    // expectations latched at accept
    always_comb
    begin
        base = (base_reg_field == 5'h0) ? 32'h0 : rf_rdata_a;
        c_st = cmd_op inside {`MLS_OP_STHBR, `MLS_OP_STWBR, `MLS_OP_STMW, `MLS_OP_STSI,
                              `MLS_OP_STSX};
        c_sz = (cmd_op == `MLS_OP_LHBR || cmd_op == `MLS_OP_STHBR) ? `MLS_SZ_HALF
            : (cmd_op <= `MLS_OP_STMW) ? `MLS_SZ_WORD : `MLS_SZ_BYTE;
        c_ea = base + rf_rdata_b;
        case (cmd_op)
            `MLS_OP_LHBR, `MLS_OP_LWBR, `MLS_OP_STHBR, `MLS_OP_STWBR: c_req = 8'h1;
            `MLS_OP_LMW, `MLS_OP_STMW: c_req = 8'h20 - {3'h0, target_reg_field};
            `MLS_OP_LSI, `MLS_OP_STSI: c_req = (immediate_byte_count_field == 5'h0)
                ? 8'h20 : {3'h0, immediate_byte_count_field};
            `MLS_OP_LSX, `MLS_OP_STSX: c_req = {1'h0, fixed_point_exception_reg[6:0]};
            default: c_req = 8'h0;
        endcase
        if (cmd_op == `MLS_OP_LMW || cmd_op == `MLS_OP_STMW)
            c_ea = base + {{16{cmd_disp[15]}}, cmd_disp};
        if (cmd_op == `MLS_OP_LSI || cmd_op == `MLS_OP_STSI)
            c_ea = base;
        c_wr = c_st ? 8'h0 : (c_sz == `MLS_SZ_BYTE) ? (c_req + 8'h3) >> 2 : c_req;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {st_reg, first_reg, sz_reg, wa_reg} <= '0;
            {req_reg, wr_reg, rcnt_reg, wcnt_reg, ea_reg, last_reg} <= '0;
        end
        else if (acc)
        begin
            {st_reg, first_reg, sz_reg, wa_reg} <= {c_st, 1'b1, c_sz, target_reg_field};
            {req_reg, wr_reg, rcnt_reg, wcnt_reg, ea_reg} <= {c_req, c_wr, 16'h0, c_ea};
        end
        else
        begin
            if (mhs)
                {first_reg, last_reg, rcnt_reg} <= {1'b0, mem_addr, rcnt_reg + 8'h1};
            if (whs)
                {wa_reg, wcnt_reg} <= {wa_reg + 5'h1, wcnt_reg + 8'h1};
        end
    end

    a_busy_ready_excl: assert property (busy != cmd_ready)
        else $error("busy vs ready");
    // a zero-count op taken in the done cycle pulses done again
    a_done_one_cycle: assert property (done && !acc |=> !done)
        else $error("done too long");
    a_req_held_stable: assert property (mem_valid && !mem_ready |=> mem_valid
        && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_we) && $stable(mem_size))
        else $error("request moved");
    a_first_addr_ok: assert property (mem_valid && first_reg |-> mem_addr == ea_reg)
        else $error("first address");
    a_addr_step_ok: assert property (mhs && !first_reg |-> mem_addr == last_reg
        + ((sz_reg == `MLS_SZ_WORD) ? 32'h4 : 32'h1))
        else $error("address step");
    a_size_kind_ok: assert property (mem_valid |-> mem_size == sz_reg && mem_we == st_reg)
        else $error("size or direction");
    a_req_count_ok: assert property (done |-> rcnt_reg == req_reg)
        else $error("request count");
    a_wr_count_ok: assert property (done |-> wcnt_reg == wr_reg)
        else $error("write count");
    a_wr_reg_order: assert property (whs |-> rf_waddr == wa_reg)
        else $error("write order");
    a_zero_cnt_done: assert property (acc && (cmd_op == `MLS_OP_LSX
        || cmd_op == `MLS_OP_STSX) && fixed_point_exception_reg[6:0] == 7'h0 |=> done)
        else $error("empty string slow");

    c_buffer_full: cover property (mem_rvalid && !mem_rready);
    c_reg_wrap: cover property (whs && rf_waddr == 5'h1f ##[1:60] whs && rf_waddr == 5'h0);
    c_zero_count: cover property (acc && cmd_op == `MLS_OP_LSX
        && fixed_point_exception_reg[6:0] == 7'h0);
endmodule // mls_seq_chk

bind mls_sequencer mls_seq_chk chk_u (.*);
`default_nettype wire

// ### mls_mem_model.sv
/*
 * memory model: byte store, random stalls, in-order read beats.
 * assumes low-aligned data, byte at the address highest.
 */
`default_nettype none

// ****************************************
// memory model
// ****************************************
module mls_mem_model (
    input wire logic        clk, reset_n, slow, mem_valid, mem_we, mem_rready,
    input wire logic [1:0]  mem_size,
    input wire logic [31:0] mem_addr, mem_wdata,
    output var logic        mem_ready, mem_rvalid,
    output var logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [logic [31:0]];
    logic [31:0] rq [$];
    logic [31:0] v;
    logic        go;
    int          nb;

    // untouched bytes read as a pattern of their address
    function automatic logic [7:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {mem_ready, mem_rvalid, mem_rdata} <= '0;
            rq.delete();
        end
        else
        begin
            nb = 1 << mem_size;
            v  = 32'h0;
            go = !slow || $urandom_range(1);
            if (mem_valid && mem_ready)
                for (int i = 0; i < nb; i++)
                    if (mem_we)
                        mem[mem_addr + i] = mem_wdata[8 * (nb - 1 - i) +: 8];
                    else
                        v = {v[23:0], rd(mem_addr + i)};
            if (mem_valid && mem_ready && !mem_we)
                rq.push_back(v);
            if (mem_rvalid && mem_rready)
                void'(rq.pop_front());
            mem_ready <= !slow || $urandom_range(1);
            // offered beat held; idle data toggles to expose stale reads
            if (!mem_rvalid || mem_rready)
            begin
                mem_rvalid <= go && rq.size() > 0;
                mem_rdata  <= (go && rq.size() > 0) ? rq[0] : ~mem_rdata;
            end
        end
    end
endmodule // mls_mem_model
`default_nettype wire

// ### tb_top.sv
/*
 * sequencer bench: register file, directed corners, seeded random ops.
 * assumes the memory model and bound checker compile alongside.
 */
`include "mls_defs.vh"
`default_nettype none

// ****************************************
// bench
// ****************************************
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, cmd_valid, cmd_ready, rf_we, rf_wready, busy, done;
    logic        mem_valid, mem_ready, mem_we, mem_rvalid, mem_rready, slow, hold, saw_full;
    logic [3:0]  cmd_op;
    logic [4:0]  target_reg_field, base_reg_field, index_reg_field, rf_waddr;
    logic [4:0]  immediate_byte_count_field, rf_raddr_a, rf_raddr_b;
    logic [15:0] cmd_disp;
    logic [1:0]  mem_size;
    logic [31:0] fixed_point_exception_reg, rf_rdata_a, rf_rdata_b, rf_wdata;
    logic [31:0] mem_addr, mem_wdata, mem_rdata;
    logic [31:0] gpr [32];
    int          n_errors, comparisons, cyc;

    mls_sequencer dut_u (.*);
    mls_mem_model mem_u (.*);

    assign rf_rdata_a = gpr[rf_raddr_a];
    assign rf_rdata_b = gpr[rf_raddr_b];

    always #25 clk = ~clk;

    always @(posedge clk)
    begin
        if (rf_we && rf_wready)
            gpr[rf_waddr] <= rf_wdata;
        saw_full  <= saw_full | (mem_rvalid & ~mem_rready);
        rf_wready <= #1 !hold && (!slow || $urandom_range(1));
        cyc       <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one command, then registers and memory compared
    task automatic run_op(input logic [3:0] op, input logic [4:0] t, a, b, nb,
                          input logic [15:0] d = 16'h0, input logic [6:0] xc = 7'h0);
        logic [31:0] g [32], eg [32];
        logic [31:0] ea;
        logic [4:0]  r;
        logic        ld;
        int          n, ln, k;
        g  = gpr;
        eg = gpr;
        ld = op inside {`MLS_OP_LHBR, `MLS_OP_LWBR, `MLS_OP_LMW, `MLS_OP_LSI, `MLS_OP_LSX};
        ea = (a == 5'h0) ? 32'h0 : g[a];
        if (op == `MLS_OP_LMW || op == `MLS_OP_STMW)
            ea += {{16{d[15]}}, d};
        else if (op != `MLS_OP_LSI && op != `MLS_OP_STSI)
            ea += g[b];
        case (op)
            `MLS_OP_LHBR, `MLS_OP_STHBR: n = 2;
            `MLS_OP_LWBR, `MLS_OP_STWBR: n = 4;
            `MLS_OP_LMW, `MLS_OP_STMW: n = 4 * (32 - t);
            `MLS_OP_LSI, `MLS_OP_STSI: n = (nb == 5'h0) ? 32 : nb;
            `MLS_OP_LSX, `MLS_OP_STSX: n = xc;
            default: n = 0;
        endcase
        {cmd_op, target_reg_field, base_reg_field, index_reg_field} = {op, t, a, b};
        {immediate_byte_count_field, cmd_disp} = {nb, d};
        fixed_point_exception_reg = {25'($urandom), xc};
        cmd_valid = 1'b1;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 4000)
        begin
            @(posedge clk);
            #1 k++;
        end
        check(32'(k < 4000), 32'h1);
        for (int i = 0; i < n; i++)
        begin
            r  = t + 5'(i / 4);
            ln = (op < `MLS_OP_LMW) ? i : 3 - i % 4;
            if (ld && i % 4 == 0)
                eg[r] = 32'h0;
            if (ld)
                eg[r][8 * ln +: 8] = mem_u.rd(ea + i);
            else
                check(32'(mem_u.rd(ea + i)), 32'(g[r][8 * ln +: 8]));
        end
        for (int j = 0; j < 32; j++)
            if (op != `MLS_OP_LSX || n != 0 || j != t)
                check(gpr[j], eg[j]);
    endtask

    task automatic rand_op();
        logic [3:0] op;
        logic [4:0] t, a;
        op = 4'($urandom_range(9));
        t  = 5'($urandom);
        a  = 5'($urandom);
        if (op == `MLS_OP_LMW)
        begin
            t = 5'($urandom_range(31, 1));
            a = 5'($urandom_range(t - 1));
        end
        run_op(op, t, a, 5'($urandom), 5'($urandom), 16'($urandom), 7'($urandom_range(32)));
    endtask

    initial
    begin
        {clk, reset_n, cmd_valid, cmd_op, target_reg_field, base_reg_field} = '0;
        {index_reg_field, immediate_byte_count_field, cmd_disp} = '0;
        {fixed_point_exception_reg, slow, hold, saw_full} = '0;
        {n_errors, comparisons, cyc} = '0;
        rf_wready = 1'b1;
        void'($urandom(52));
        foreach (gpr[j])
            gpr[j] = $urandom;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        // every code, back to back
        for (int o = 0; o < 16; o++)
            run_op(4'(o), 5'h1c, 5'h3, 5'h4, 5'h9, 16'hfff6, 7'h5);
        run_op(`MLS_OP_LSI, 5'h1e, 5'h0, 5'h0, 5'h0);
        run_op(`MLS_OP_STSI, 5'h1f, 5'h2, 5'h0, 5'h0);
        run_op(`MLS_OP_LSX, 5'h7, 5'h2, 5'h3, 5'h0);
        run_op(`MLS_OP_STSX, 5'h7, 5'h2, 5'h5, 5'h0);
        run_op(`MLS_OP_LSX, 5'h1f, 5'h9, 5'ha, 5'h0, 16'h0, 7'h7);
        run_op(`MLS_OP_STMW, 5'h0, 5'h0, 5'h0, 5'h0, 16'h8000);
        run_op(`MLS_OP_LHBR, 5'h5, 5'h0, 5'h6, 5'h0);
        // register port stalled: load buffer fills
        saw_full = 1'b0;
        hold = 1'b1;
        fork
            begin
                repeat (80) @(posedge clk);
                #1 hold = 1'b0;
            end
        join_none
        run_op(`MLS_OP_LMW, 5'h1, 5'h0, 5'h0, 5'h0, 16'h0010);
        check(32'(saw_full), 32'h1);
        slow = 1'b1;
        repeat (150) rand_op();
        slow = 1'b0;
        repeat (100) rand_op();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
